// ==== pd_ctrl_pkg.sv ====
// Purpose: Constants for the sensor power-down control block
// Assumes: mclk at 50 MHz, serial clock from the host on its own domain
// Notes: Timing counts derive from printed times and the clock rate
//
// Contract
// - A serial write of one to bit 6 enters low power.
// - A serial write of zero to bit 6 leaves low power.
// - Transaction timeout is off while asleep; host sends only whole commands.
// - While asleep, configuration writes change only bit 6.
// - Register contents stay unchanged during low power.
// - Configuration register decodes at seven-bit address 1000000.
// - Sleep bit puts analog circuitry at zero current; digital state kept.
// - Shutter drive and serial data pin float while asleep.
// - Serial port resets if a transaction lasts beyond about 90 ms.
// - Reports valid within 610 us plus 75 frames, at most 50 ms, after wake.
// - Reports valid within 610 us plus 50 frames, at most 40 ms, after power.
// - A write is two bytes: direction one plus address, then data.
// - Timeout runs from first serial clock edge to sixteenth rising edge.
package pd_ctrl_pkg;
    localparam int CLK_HZ = 50_000_000;
    localparam logic [6:0] CONFIG_ADDR = 7'h40;
    localparam int SLEEP_BIT = 6;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam int SLEEP_SETTLE_CYC = 32;
    localparam int TIMEOUT_MS = 90;
    localparam int TIMEOUT_CYC = (CLK_HZ / 1000) * TIMEOUT_MS;
    localparam int BASE_WAKE_US = 610;
    localparam int BASE_WAKE_CYC = (CLK_HZ / 1_000_000) * BASE_WAKE_US;
    localparam int FRAME_RATE = 1500;
    localparam int FRAME_CYC = CLK_HZ / FRAME_RATE;
    localparam int WAKE_FRAMES = 75;
    localparam int POWERUP_FRAMES = 50;
    localparam int WAKE_MAX_MS = 50;
    localparam int POWERUP_MAX_MS = 40;
    localparam int WAKE_CYC = BASE_WAKE_CYC + WAKE_FRAMES * FRAME_CYC;
    localparam int POWERUP_CYC = BASE_WAKE_CYC + POWERUP_FRAMES * FRAME_CYC;
    localparam int WAKE_MAX_CYC = (CLK_HZ / 1000) * WAKE_MAX_MS;
    localparam int POWERUP_MAX_CYC = (CLK_HZ / 1000) * POWERUP_MAX_MS;
    localparam int WAKE_DONE_CYC = (WAKE_CYC < WAKE_MAX_CYC) ? WAKE_CYC : WAKE_MAX_CYC;
    localparam int POWERUP_DONE_CYC =
        (POWERUP_CYC < POWERUP_MAX_CYC) ? POWERUP_CYC : POWERUP_MAX_CYC;
    localparam int BITS_PER_XFER = 16;
endpackage

// ==== pd_link_shift.sv ====
// Purpose: Serial-clock side shifter for two-byte host transactions
// Assumes: Host changes data on falling edges, device samples on rising
// Notes: Cleared asynchronously by the port reset from the main domain
`timescale 1ns/1ps
`default_nettype none
module pd_link_shift
    import pd_ctrl_pkg::*;
(
    input wire logic sck,
    input wire logic port_rst,
    input wire logic sdio_in,
    output logic [15:0] frame_reg,
    output logic [4:0] count_reg,
    output logic done_toggle_reg
);
    logic [15:0] frame_next;
    logic [4:0] count_next;
    logic last_bit;

    assign frame_next = {frame_reg[14:0], sdio_in};
    assign last_bit = (count_reg == 5'(BITS_PER_XFER - 1));
    assign count_next = last_bit ? 5'h00 : count_reg + 5'h01;

    always_ff @(posedge sck or posedge port_rst) begin
        if (port_rst) begin
            frame_reg <= 16'h0000;
            count_reg <= 5'h00;
            done_toggle_reg <= 1'b0;
        end else begin
            frame_reg <= frame_next;
            count_reg <= count_next;
            if (last_bit) begin
                done_toggle_reg <= ~done_toggle_reg;
            end
        end
    end
endmodule
`default_nettype wire

// ==== pd_ctrl.sv ====
// Purpose: Power-down control with serial configuration write port
// Assumes: sck is the host link clock; sck_sync_reg holds sck sampled as a pin
// Notes: Only writes are decoded; the data pin is never driven here
`timescale 1ns/1ps
`default_nettype none
module pd_ctrl
    import pd_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sck,
    input wire logic sdio_in,
    output logic sdio_out,
    output logic sdio_oe,
    input wire logic shutter_req,
    output logic shutter_drive_out,
    output logic shutter_oe,
    output logic [7:0] config_value,
    output logic sleep_request_bit,
    output logic analog_enable,
    output logic reports_valid,
    output logic sleep_settled
);
    typedef enum logic [1:0] {ST_POWERUP, ST_RUN, ST_SLEEP, ST_WAKE} pwr_e;

    // ****************************************
    // Link domain
    // ****************************************
    logic port_rst;
    logic port_rst_reg;
    logic [15:0] frame_reg;
    logic [4:0] count_reg;
    logic done_toggle_reg;

    // Global reset or a one-cycle timeout pulse clears the link side
    assign port_rst = rst | port_rst_reg;

    pd_link_shift u_shift (
        .sck(sck),
        .port_rst(port_rst),
        .sdio_in(sdio_in),
        .frame_reg(frame_reg),
        .count_reg(count_reg),
        .done_toggle_reg(done_toggle_reg)
    );

    // ****************************************
    // Crossings
    // ****************************************
    logic [2:0] done_sync_reg;
    logic [1:0] sck_sync_reg;
    logic sck_seen_reg;
    logic done_pulse;
    logic sck_edge;

    // Toggle from the link side becomes a one-cycle pulse here
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            done_sync_reg <= 3'h0;
        end else begin
            done_sync_reg <= {done_sync_reg[1:0], done_toggle_reg};
        end
    end

    // Resets to the idle-high level of sck so that reset makes no false edge
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            sck_sync_reg <= 2'h3;
            sck_seen_reg <= 1'b1;
        end else begin
            sck_sync_reg <= {sck_sync_reg[0], sck};
            sck_seen_reg <= sck_sync_reg[1];
        end
    end

    assign done_pulse = done_sync_reg[2] ^ done_sync_reg[1];
    assign sck_edge = sck_sync_reg[1] ^ sck_seen_reg;

    // ****************************************
    // Frame decode
    // ****************************************

    // Frame is stable for many mclk cycles after the final edge (sclk <= fclk/12)
    logic is_write;
    logic addr_hit;
    logic config_write;

    // Reads and other addresses leave the register alone
    assign is_write = frame_reg[15];
    assign addr_hit = (frame_reg[14:8] == CONFIG_ADDR);
    assign config_write = done_pulse & is_write & addr_hit;

    // ****************************************
    // Transaction timer
    // ****************************************
    // True once a cycle count has reached its limit
    function automatic logic reached(input logic [31:0] cnt, input int limit);
        logic hit;
        hit = (cnt >= 32'(limit));
        return hit;
    endfunction

    logic busy_reg;
    logic [31:0] tmo_cnt_reg;
    logic tmo_hit;
    logic sleeping;
    logic xfer_start;
    logic xfer_end;
    logic tmo_count_en;

    // Timer covers one frame from its first sck edge to the sixteenth rise
    // It is frozen, not cleared, while asleep; a half frame then waits for the host
    assign xfer_start = ~busy_reg & sck_edge;
    assign xfer_end = done_pulse | tmo_hit;
    assign tmo_count_en = busy_reg & ~sleeping;
    assign tmo_hit = tmo_count_en & reached(tmo_cnt_reg, TIMEOUT_CYC);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            busy_reg <= 1'b0;
        end else if (xfer_end) begin
            busy_reg <= 1'b0;
        end else if (xfer_start) begin
            busy_reg <= 1'b1;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            tmo_cnt_reg <= 32'h0;
        end else if (xfer_end || xfer_start) begin
            tmo_cnt_reg <= 32'h0;
        end else if (tmo_count_en) begin
            tmo_cnt_reg <= tmo_cnt_reg + 32'h1;
        end
    end

    // Port reset lasts one mclk cycle and clears the shifter asynchronously
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            port_rst_reg <= 1'b0;
        end else begin
            port_rst_reg <= tmo_hit;
        end
    end

    // ****************************************
    // Configuration register
    // ****************************************
    logic [7:0] config_reg;
    logic [7:0] config_next;
    logic [7:0] wr_data;

    assign wr_data = frame_reg[7:0];

    function automatic logic [7:0] merge_sleep(input logic [7:0] cur, input logic [7:0] wr);
        logic [7:0] res;
        res = cur;
        res[SLEEP_BIT] = wr[SLEEP_BIT];
        return res;
    endfunction

    // Awake, including powerup and wake, the whole byte is taken
    // Asleep: only the sleep bit lands, rest is kept
    assign config_next = sleeping ? merge_sleep(config_reg, wr_data) : wr_data;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            config_reg <= CONFIG_RESET;
        end else if (config_write) begin
            config_reg <= config_next;
        end
    end

    // ****************************************
    // Power sequencer
    // ****************************************
    pwr_e state_reg;
    pwr_e state_next;
    logic [31:0] seq_cnt_reg;
    logic [31:0] seq_cnt_next;
    logic [5:0] settle_cnt_reg;
    logic sleep_cmd;
    logic powerup_done;
    logic wake_done;
    logic settle_full;

    assign sleep_cmd = config_reg[SLEEP_BIT];
    assign sleeping = (state_reg == ST_SLEEP);
    // Both delays are capped at their upper bounds
    assign powerup_done = reached(seq_cnt_reg, POWERUP_DONE_CYC - 1);
    assign wake_done = reached(seq_cnt_reg, WAKE_DONE_CYC - 1);
    assign settle_full = (settle_cnt_reg >= 6'(SLEEP_SETTLE_CYC));

    // A new sleep request cuts powerup or wake short
    always_comb begin
        state_next = state_reg;
        seq_cnt_next = seq_cnt_reg + 32'h1;
        case (state_reg)
            ST_POWERUP: begin
                if (sleep_cmd) begin
                    state_next = ST_SLEEP;
                end else if (powerup_done) begin
                    state_next = ST_RUN;
                end
            end
            ST_RUN: begin
                seq_cnt_next = 32'h0;
                if (sleep_cmd) begin
                    state_next = ST_SLEEP;
                end
            end
            ST_SLEEP: begin
                seq_cnt_next = 32'h0;
                if (!sleep_cmd) begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE: begin
                if (sleep_cmd) begin
                    state_next = ST_SLEEP;
                end else if (wake_done) begin
                    state_next = ST_RUN;
                end
            end
            default: begin
                state_next = ST_POWERUP;
            end
        endcase
        if (state_next != state_reg) begin
            seq_cnt_next = 32'h0;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_POWERUP;
        end else begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            seq_cnt_reg <= 32'h0;
        end else begin
            seq_cnt_reg <= seq_cnt_next;
        end
    end

    // ****************************************
    // Sleep settle counter
    // ****************************************

    // Lets the host see when power is really off
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            settle_cnt_reg <= 6'h00;
        end else if (!sleeping) begin
            settle_cnt_reg <= 6'h00;
        end else if (!settle_full) begin
            settle_cnt_reg <= settle_cnt_reg + 6'h01;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    logic shutter_reg;
    logic valid_reg;
    logic shutter_next;
    logic valid_next;
    logic power_on;

    // Analog power and shutter enable follow the sleep state; reports follow the run state
    assign power_on = ~sleeping;
    assign shutter_next = shutter_req & power_on;
    assign valid_next = (state_next == ST_RUN);

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            shutter_reg <= 1'b0;
        end else begin
            shutter_reg <= shutter_next;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= valid_next;
        end
    end

    // The data pin is an input here: this block answers no reads
    assign sdio_out = 1'b0;
    assign sdio_oe = 1'b0;
    assign shutter_drive_out = shutter_reg;
    assign shutter_oe = power_on;
    assign config_value = config_reg;
    assign sleep_request_bit = sleep_cmd;
    assign analog_enable = power_on;
    assign reports_valid = valid_reg;
    assign sleep_settled = sleeping & settle_full;
endmodule
`default_nettype wire

// ==== pd_ctrl_asserts.sv ====
// Purpose: Port timing checks for the power-down control
// Assumes: All checked outputs live in the mclk domain
// Notes: Sleep time is counted in helper logic
`timescale 1ns/1ps
`default_nettype none
module pd_ctrl_asserts
    import pd_ctrl_pkg::*;
(
    input wire logic mclk,
    input wire logic rst,
    input wire logic sck,
    input wire logic sdio_in,
    input wire logic sdio_out,
    input wire logic sdio_oe,
    input wire logic shutter_req,
    input wire logic shutter_drive_out,
    input wire logic shutter_oe,
    input wire logic [7:0] config_value,
    input wire logic sleep_request_bit,
    input wire logic analog_enable,
    input wire logic reports_valid,
    input wire logic sleep_settled
);
    // ****************
    // Checks
    // ****************
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    logic [5:0] asleep_cnt;
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) asleep_cnt <= 6'h00;
        else if (analog_enable) asleep_cnt <= 6'h00;
        else if (asleep_cnt != 6'h3F) asleep_cnt <= asleep_cnt + 6'h01;
    end
    a_data_pin_float: assert property (!sdio_oe) else $error("sdio driven");
    a_sleep_bit_only: assert property ($past(config_value[6]) |->
        {config_value[7], config_value[5:0]} == $past({config_value[7], config_value[5:0]}))
        else $error("config changed while asleep");
    a_analog_off: assert property ($rose(config_value[6]) |-> ##[0:2] !analog_enable)
        else $error("analog not off");
    a_analog_on: assert property ($fell(config_value[6]) |-> ##[0:2] analog_enable)
        else $error("analog not on");
    a_shutter_float: assert property (!analog_enable && !$past(analog_enable) |->
        !shutter_oe && !shutter_drive_out) else $error("shutter driven asleep");
    a_settle_early: assert property (sleep_settled |-> asleep_cnt >= 6'h20)
        else $error("settled early");
    a_settle_late: assert property (!analog_enable && asleep_cnt >= 6'h24 |-> sleep_settled)
        else $error("settled late");
    a_reports_off: assert property (!analog_enable |-> !reports_valid)
        else $error("reports while asleep");
    c_settled: cover property ($rose(sleep_settled));
    c_wake: cover property ($fell(config_value[6]));
    c_write: cover property ($changed(config_value));
endmodule
bind pd_ctrl pd_ctrl_asserts chk_u (.*);
`default_nettype wire

// ==== host_model.sv ====
// Purpose: Host side of the two-wire serial port
// Assumes: Link clock idles high and stands still between frames
// Notes: Each frame is followed by the write-to-write gap
`timescale 1ns/1ps
`default_nettype none
module host_model (
    output logic sck,
    output logic sdio
);
    initial begin
        sck = 1'b1;
        sdio = 1'b0;
    end
    // ****************
    // Frame driver
    // ****************
    task automatic xfer(input logic [15:0] frame);
        #13;
        for (int i = 15; i >= 0; i--) begin
            sck = 1'b0;
            sdio = frame[i];
            #32;
            sck = 1'b1;
            #32;
        end
        sdio = ~frame[0];
        #100us;
    endtask
endmodule
`default_nettype wire

// ==== pd_ctrl_tb.sv ====
// Purpose: Self-checking bench for the power-down control
// Assumes: Host model drives the link; bench drives mclk side
// Notes: Long wake counts are checked neither here nor by the checker
`timescale 1ns/1ps
`default_nettype none
module pd_ctrl_tb;
    import pd_ctrl_pkg::*;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic shutter_req = 1'b0;
    wire logic sck;
    wire logic sdio_in;
    logic sdio_out, sdio_oe, shutter_drive_out, shutter_oe, sleep_request_bit;
    logic analog_enable, reports_valid, sleep_settled;
    logic [7:0] config_value;
    int bad_count = 0;
    int checked = 0;
    always #10 mclk = ~mclk;
    host_model host_u (.sck(sck), .sdio(sdio_in));
    pd_ctrl dut_u (.mclk(mclk), .rst(rst), .sck(sck), .sdio_in(sdio_in), .sdio_out(sdio_out),
        .sdio_oe(sdio_oe), .shutter_req(shutter_req), .shutter_drive_out(shutter_drive_out),
        .shutter_oe(shutter_oe), .config_value(config_value),
        .sleep_request_bit(sleep_request_bit), .analog_enable(analog_enable),
        .reports_valid(reports_valid), .sleep_settled(sleep_settled));
    // ****************
    // Helpers and scenarios
    // ****************
    task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task end_of_test;
        if (bad_count == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task write_cfg(input logic [7:0] d);
        host_u.xfer({1'b1, CONFIG_ADDR, d});
        @(negedge mclk);
    endtask
    task test_reset;
        check("config", config_value, CONFIG_RESET);
        check("reports", {7'h00, reports_valid}, 8'h00);
        check("shutter_oe", {7'h00, shutter_oe}, 8'h01);
    endtask
    task test_decode;
        write_cfg(8'h25);
        check("config", config_value, 8'h25);
        host_u.xfer({1'b1, 7'h41, 8'hFF});
        check("other addr", config_value, 8'h25);
        host_u.xfer({1'b0, CONFIG_ADDR, 8'h00});
        check("read frame", config_value, 8'h25);
    endtask
    task test_sleep;
        @(negedge mclk);
        shutter_req = 1'b1;
        write_cfg(8'h25 | 8'h40);
        check("config", config_value, 8'h65);
        check("sleep bit", {7'h00, sleep_request_bit}, 8'h01);
        check("analog", {7'h00, analog_enable}, 8'h00);
        check("shutter", {6'h00, shutter_oe, shutter_drive_out}, 8'h00);
        check("sdio", {6'h00, sdio_oe, sdio_out}, 8'h00);
        check("settled", {7'h00, sleep_settled}, 8'h01);
    endtask
    task test_asleep_writes;
        write_cfg(8'hDA);
        check("asleep write", config_value, 8'h65);
        write_cfg(8'h9A);
        check("wake", config_value, (8'h65 & ~8'h40) | (8'h9A & 8'h40));
        check("analog", {7'h00, analog_enable}, 8'h01);
        check("reports", {7'h00, reports_valid}, 8'h00);
        shutter_req = 1'b0;
        repeat (3) @(negedge mclk);
        check("shutter low", {6'h00, shutter_oe, shutter_drive_out}, 8'h02);
        shutter_req = 1'b1;
        repeat (3) @(negedge mclk);
        check("shutter high", {6'h00, shutter_oe, shutter_drive_out}, 8'h03);
    endtask
    initial begin
        #1ms;
        bad_count++;
        end_of_test();
    end
    initial begin
        repeat (4) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        repeat (2) @(negedge mclk);
        test_reset();
        test_decode();
        test_sleep();
        test_asleep_writes();
        end_of_test();
    end
endmodule
`default_nettype wire
